// file: rtl/pt_defines.vh
// Contract
// - each period match clocks a 4-bit postscaler, and when it reaches its selected count the match interrupt flag is set and stays latched.
// - the interrupt request leaves the block only while the match interrupt enable is set, though the flag latches regardless.
// - control bits 6 to 3 select a postscale ratio of field value plus one, from 1:1 to 1:16.
// - the unscaled match pulse, taken before the postscaler, is exported as the PWM time base.
// - the match pulse is offered as a selectable shift clock source for the serial port in SPI mode.
// - while in sleep the timer neither counts, compares nor produces match pulses.
// - sleep leaves the count and period registers unchanged so counting resumes from them.
// - control bit 2 turns the timer on when 1 and stops it when 0.
// - control bits 1 to 0 select a prescale of 1, 4, 16 or 64.
// - control bit 7 is unimplemented, reads zero and ignores writes.
// - the count increments from zero on each prescaled instruction clock tick, the instruction clock being the oscillator divided by four.
// - the count is compared with the period on each prescaled tick, and on equality a match pulse is raised and the count reloads zero at that tick.
// - on reset the count clears to zero and the period initialises to all ones.
// - prescaler and postscaler clear on a write to the count or control register and on reset, and a control write leaves the count alone.
`ifndef PT_DEFINES_VH
`define PT_DEFINES_VH
`define PT_OFF_CONTROL 12'h000
`define PT_OFF_COUNT 12'h004
`define PT_OFF_PERIOD 12'h008
`define PT_OFF_IRQ 12'h00c
`define PT_CTRL_RESET 8'h00
`define PT_COUNT_RESET 8'h00
`define PT_PERIOD_RESET 8'hff
`define PT_CTRL_ON 2
`define PT_IRQ_FLAG 0
`define PT_IRQ_EN 1
`define PT_INSTR_DIV 2'h3
`endif

// file: rtl/pt_prescaler.v
`timescale 1ns/10ps
`default_nettype none
module pt_prescaler (
   input wire pclk,
   input wire presetn,
   input wire clear,
   input wire advance,
   input wire [1:0] select,
   output wire tick
);
   reg [5:0] count_reg;
   reg [5:0] limit;
   always @* begin
      case (select)
         2'h0: limit = 6'h00;
         2'h1: limit = 6'h03;
         2'h2: limit = 6'h0f;
         default: limit = 6'h3f;
      endcase
   end
   assign tick = advance && (count_reg >= limit);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 6'h00;
      end else if (clear) begin
         count_reg <= 6'h00;
      end else if (advance) begin
         if (count_reg >= limit) begin
            count_reg <= 6'h00;
         end else begin
            count_reg <= count_reg + 6'h01;
         end
      end
   end
endmodule
`default_nettype wire

// file: rtl/pt_timer.v
`timescale 1ns/10ps
`default_nettype none
`include "pt_defines.vh"
module pt_timer (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire sleep,
   output reg pwm_time_base,
   output reg spi_shift_clock,
   output wire match_irq
);
   reg [7:0] control_reg;
   reg [7:0] count_reg;
   reg [7:0] period_reg;
   reg match_irq_flag_reg;
   reg match_irq_enable_reg;
   reg [1:0] instr_div_reg;
   reg [3:0] post_count_reg;
   reg clear_pending_reg;
   wire wr;
   wire rd;
   wire mapped;
   wire running;
   wire instr_tick;
   wire pre_tick;
   wire match;
   wire post_done;
   wire wr_count;
   wire wr_control;
   wire scaler_clear;

   // zero-wait slave; every access finishes in its first access cycle
   assign pready = 1'b1;
   assign mapped = (paddr == `PT_OFF_CONTROL) || (paddr == `PT_OFF_COUNT) ||
      (paddr == `PT_OFF_PERIOD) || (paddr == `PT_OFF_IRQ);
   assign pslverr = psel && penable && !mapped;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign wr_count = wr && (paddr == `PT_OFF_COUNT);
   assign wr_control = wr && (paddr == `PT_OFF_CONTROL);
   assign scaler_clear = wr_count || wr_control;

   // sleep freezes everything on the counting path
   assign running = control_reg[`PT_CTRL_ON] && !sleep;
   assign instr_tick = running && (instr_div_reg == `PT_INSTR_DIV);
   assign match = pre_tick && (count_reg == period_reg);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_div_reg <= 2'h0;
      end else if (running) begin
         instr_div_reg <= instr_div_reg + 2'h1;
      end
   end

   pt_prescaler u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .clear(scaler_clear),
      .advance(instr_tick),
      .select(control_reg[1:0]),
      .tick(pre_tick)
   );

   // comparison waits for a tick so one match per period, not per pclk
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= `PT_COUNT_RESET;
         period_reg <= `PT_PERIOD_RESET;
      end else begin
         if (wr_count) begin
            count_reg <= pwdata[7:0];
         end else if (match) begin
            count_reg <= 8'h00;
         end else if (pre_tick) begin
            count_reg <= count_reg + 8'h01;
         end
         if (wr && (paddr == `PT_OFF_PERIOD)) begin
            period_reg <= pwdata[7:0];
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_reg <= `PT_CTRL_RESET;
      end else if (wr_control) begin
         control_reg <= {1'b0, pwdata[6:0]};
      end
   end

   assign post_done = match && (post_count_reg == control_reg[6:3]);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         post_count_reg <= 4'h0;
         clear_pending_reg <= 1'b0;
      end else begin
         clear_pending_reg <= 1'b0;
         if (scaler_clear) begin
            post_count_reg <= 4'h0;
         end else if (post_done) begin
            post_count_reg <= 4'h0;
         end else if (match) begin
            post_count_reg <= post_count_reg + 4'h1;
         end
      end
   end

   // hardware set wins over a software clear in the same cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_irq_flag_reg <= 1'b0;
         match_irq_enable_reg <= 1'b0;
      end else begin
         if (post_done) begin
            match_irq_flag_reg <= 1'b1;
         end else if (wr && (paddr == `PT_OFF_IRQ)) begin
            match_irq_flag_reg <= pwdata[`PT_IRQ_FLAG];
         end
         if (wr && (paddr == `PT_OFF_IRQ)) begin
            match_irq_enable_reg <= pwdata[`PT_IRQ_EN];
         end
      end
   end

   assign match_irq = match_irq_flag_reg && match_irq_enable_reg;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_time_base <= 1'b0;
         spi_shift_clock <= 1'b0;
      end else begin
         pwm_time_base <= match;
         spi_shift_clock <= match;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `PT_OFF_CONTROL: prdata <= {24'h000000, 1'b0, control_reg[6:0]};
            `PT_OFF_COUNT: prdata <= {24'h000000, count_reg};
            `PT_OFF_PERIOD: prdata <= {24'h000000, period_reg};
            `PT_OFF_IRQ: prdata <= {30'h00000000, match_irq_enable_reg, match_irq_flag_reg};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: test/pt_pulse_sink.sv
`timescale 1ns/10ps
`default_nettype none
module pt_pulse_sink (
   input wire pclk,
   input wire presetn,
   input wire time_base,
   input wire shift_clock,
   output logic [15:0] pulses
);
   // counts only when both consumers see the match together
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulses <= 16'h0;
      end else if (time_base && shift_clock) begin
         pulses <= pulses + 16'h1;
      end
   end
endmodule
`default_nettype wire

// file: test/pt_timer_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "pt_defines.vh"
module pt_timer_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire sleep,
   input wire pwm_time_base,
   input wire spi_shift_clock,
   input wire match_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   wire irq_wr = acc && pwrite && paddr == `PT_OFF_IRQ;
   spi_same_a: assert property (spi_shift_clock == pwm_time_base)
      else $error("shift clock differs");
   pulse_gap_a: assert property (pwm_time_base |=> !pwm_time_base [*3])
      else $error("pulses too close");
   sleep_quiet_a: assert property (sleep [*3] |-> !pwm_time_base)
      else $error("pulse in sleep");
   irq_cause_a: assert property ($rose(match_irq) |->
      pwm_time_base || $past(pwm_time_base) || $past(irq_wr)) else $error("irq without cause");
   irq_hold_a: assert property ($fell(match_irq) |-> $past(irq_wr))
      else $error("irq dropped by itself");
   bit7_zero_a: assert property (acc && !pwrite && paddr == `PT_OFF_CONTROL |->
      prdata[31:7] == 25'h0) else $error("control top bits set");
   bad_addr_a: assert property (acc && !pwrite && paddr > `PT_OFF_IRQ |->
      pslverr && prdata == 32'h0) else $error("unmapped read accepted");
   zero_wait_a: assert property (acc |-> pready)
      else $error("wait state seen");
   cover property (match_irq);
   cover property (sleep [*3]);
   cover property (pwm_time_base ##8 pwm_time_base);
endmodule
`default_nettype wire

// file: test/pt_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pt_defines.vh"
module pt_timer_tb;
   logic pclk, presetn, psel, penable, pwrite, sleep, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   wire pready, pslverr, pwm_time_base, spi_shift_clock, match_irq;
   wire [15:0] pulses;
   int mismatches, total_checks, n, i;
   pt_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .sleep, .pwm_time_base, .spi_shift_clock, .match_irq);
   pt_pulse_sink sink (.pclk, .presetn, .time_base(pwm_time_base),
      .shift_clock(spi_shift_clock), .pulses);
   initial begin
      pclk = 0;
      forever #50 pclk = ~pclk;
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hang(input int k, input int lim);
      if (k >= lim) begin
         mismatches++;
         summarize();
      end
   endtask
   // one apb transfer, then an idle cycle so strobes never double up
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      hang(k, 50);
      @(posedge pclk);
   endtask
   task automatic gap(input int lim);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pwm_time_base !== 1'b1 && n < lim);
      hang(n, lim);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, sleep, paddr, pwdata} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      bus(0, `PT_OFF_PERIOD, 0); chk(rd, 32'hff);
      bus(0, `PT_OFF_COUNT, 0); chk(rd, 32'h0);
      bus(1, `PT_OFF_CONTROL, 32'h80); bus(0, `PT_OFF_CONTROL, 0); chk(rd, 32'h0);
      bus(1, `PT_OFF_CONTROL, 32'hfb); bus(0, `PT_OFF_CONTROL, 0); chk(rd, 32'h7b);
      bus(0, 12'h010, 0); chk({rd[30:0], err}, 32'h1);
      $display("registers done");
      bus(1, `PT_OFF_PERIOD, 1);
      for (i = 0; i < 4; i++) begin
         bus(1, `PT_OFF_CONTROL, 4 | i);
         gap(600);
         gap(600); chk(n, 8 << (2 * i));
      end
      $display("prescale done");
      foreach (v[i]) if (i == 0 || i == 15) begin
         bus(1, `PT_OFF_CONTROL, 0);
         bus(1, `PT_OFF_IRQ, 2);
         n = pulses;
         bus(1, `PT_OFF_CONTROL, (i << 3) | 4);
         for (int k = 0; k < 400 && match_irq !== 1'b1; k++) @(posedge pclk);
         repeat (2) @(posedge pclk);
         chk(match_irq, 1);
         chk(pulses - n, i + 1);
      end
      bus(1, `PT_OFF_CONTROL, 0);
      bus(1, `PT_OFF_IRQ, 1); chk(match_irq, 0);
      bus(0, `PT_OFF_IRQ, 0); chk(rd, 32'h1);
      bus(1, `PT_OFF_IRQ, 0); bus(0, `PT_OFF_IRQ, 0); chk(rd, 32'h0);
      $display("postscale done");
      bus(1, `PT_OFF_PERIOD, 32'h40);
      for (i = 0; i < 2; i++) begin
         bus(1, `PT_OFF_CONTROL, 4);
         repeat (30) @(posedge pclk);
         if (i == 0) sleep <= 1'b1; else bus(1, `PT_OFF_CONTROL, 0);
         bus(0, `PT_OFF_COUNT, 0); v = rd; n = pulses;
         repeat (40) @(posedge pclk);
         bus(0, `PT_OFF_COUNT, 0); chk(rd, v);
         bus(0, `PT_OFF_PERIOD, 0); chk(rd, 32'h40);
         sleep <= 1'b0;
         chk(pulses, n);
      end
      $display("hold done");
      bus(1, `PT_OFF_COUNT, 32'h25); bus(0, `PT_OFF_COUNT, 0); chk(rd, 32'h25);
      bus(1, `PT_OFF_CONTROL, 0); bus(0, `PT_OFF_COUNT, 0); chk(rd, 32'h25);
      $display("count write done");
      summarize();
   end
endmodule
bind pt_timer pt_timer_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .sleep, .pwm_time_base, .spi_shift_clock, .match_irq);
`default_nettype wire
